// [rtl/smx_regs.vh]
// Register map, field layout and reset values of the serial input mix block
`ifndef SMX_REGS_VH
`define SMX_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SMX_IDX_MIX_CFG 6'h0a
`define SMX_IDX_FIRST_CHANNEL_SLOT 6'h0b
`define SMX_IDX_SECOND_CHANNEL_SLOT 6'h0c
`define SMX_IDX_PORT_CFG 6'h10
`define SMX_IDX_STATUS 6'h11

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SMX_MIX_SEL_HI 7
`define SMX_MIX_SEL_LO 6
`define SMX_ATT_HI 5
`define SMX_ATT_LO 4
`define SMX_INV_BIT 3
`define SMX_SLOT_HI 5
`define SMX_SLOT_LO 0
`define SMX_FMT_HI 1
`define SMX_FMT_LO 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMX_MIX_CFG_RST 8'h00
`define SMX_FIRST_CHANNEL_SLOT_RST 6'h00
`define SMX_SECOND_CHANNEL_SLOT_RST 6'h01
`define SMX_FMT_RST 2'h0

// ----------------------------------------------------------------------------
// Modes and frame layout
// ----------------------------------------------------------------------------
`define SMX_MIX_NONE 2'h0
`define SMX_MIX_TO_CH1 2'h1
`define SMX_MIX_TO_CH2 2'h2
`define SMX_MIX_INDEP 2'h3
`define SMX_FMT_TDM 2'h0
`define SMX_FMT_I2S 2'h1
`define SMX_FMT_LJ 2'h2
`define SMX_SLOT_BITS 5'h1f

`endif

// [rtl/smx_mix.v]
// One output channel mixer: attenuate, invert and add serial input data
module smx_mix (
   input wire [31:0] own_smp,
   input wire [31:0] other_smp,
   input wire other_en,
   input wire [31:0] ser_smp,
   input wire ser_en,
   input wire [1:0] atten,
   input wire invert,
   output reg [31:0] mix_out
);
   reg signed [33:0] scaled;
   reg signed [33:0] sum;

   always @* begin
      // Each step of atten is a halving, about 6 dB
      scaled = $signed({{2{ser_smp[31]}}, ser_smp}) >>> atten;
      if (invert) begin
         scaled = 34'sh0 - scaled;
      end
      sum = {{2{own_smp[31]}}, own_smp};
      if (other_en) begin
         sum = sum + {{2{other_smp[31]}}, other_smp};
      end
      if (ser_en) begin
         sum = sum + scaled;
      end
      if (sum > 34'sh0_7fff_ffff) begin
         mix_out = 32'h7fff_ffff;
      end else if (sum < -34'sh0_8000_0000) begin
         mix_out = 32'h8000_0000;
      end else begin
         mix_out = sum[31:0];
      end
   end
endmodule

// [rtl/smx_top.v]
// Serial input mixing and output slot mapping for two converter channels
//
// Design decision made here: the APB interface to the registers.
`include "smx_regs.vh"

module smx_top (
   input wire ref_clk,
   input wire reset,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [31:0] ch1_smp,
   input wire [31:0] ch2_smp,
   input wire bclk,
   input wire fsync,
   input wire general_input_pin,
   output reg sdout,
   output reg sdout_oe
);

   // -------------------------------------------------------------------------
   // Configuration and state
   // -------------------------------------------------------------------------
   reg [1:0] mix_sel_q;
   reg [1:0] att_q;
   reg mix_input_invert_q;
   reg [5:0] first_channel_slot_q;
   reg [5:0] second_channel_slot_q;
   reg [1:0] fmt_q;
   reg [7:0] frame_cnt_q;

   reg bclk_m_q;
   reg bclk_s_q;
   reg bclk_p_q;
   reg fs_m_q;
   reg fs_s_q;
   reg fs_last_q;
   reg din_m_q;
   reg din_s_q;

   reg [10:0] pos_q;
   reg pos_vld_q;
   reg right_q;
   reg [31:0] rx_sh_q;
   reg [31:0] in1_q;
   reg [31:0] in2_q;
   reg [31:0] tx1_q;
   reg [31:0] tx2_q;

   wire [5:0] idx = paddr[7:2];
   wire setup = psel & ~penable;
   wire acc_done = psel & penable & pready;
   wire mapped;
   reg [31:0] rd_val;
   // Field reset values of the mix register
   wire [7:0] mix_rst = `SMX_MIX_CFG_RST;

   // -------------------------------------------------------------------------
   // APB slave: no wait cycle, answer from flip-flops
   // -------------------------------------------------------------------------
   assign mapped = (paddr[1:0] == 2'h0) &&
      ((idx == `SMX_IDX_MIX_CFG) || (idx == `SMX_IDX_FIRST_CHANNEL_SLOT) ||
       (idx == `SMX_IDX_SECOND_CHANNEL_SLOT) || (idx == `SMX_IDX_PORT_CFG) ||
       (idx == `SMX_IDX_STATUS));

   always @* begin
      rd_val = 32'h0000_0000;
      case (idx)
         `SMX_IDX_MIX_CFG: begin
            // Low three bits stay zero
            rd_val = {24'h000000, mix_sel_q, att_q, mix_input_invert_q, 3'h0};
         end
         `SMX_IDX_FIRST_CHANNEL_SLOT: begin
            rd_val = {26'h0000000, first_channel_slot_q};
         end
         `SMX_IDX_SECOND_CHANNEL_SLOT: begin
            rd_val = {26'h0000000, second_channel_slot_q};
         end
         `SMX_IDX_PORT_CFG: begin
            rd_val = {30'h00000000, fmt_q};
         end
         `SMX_IDX_STATUS: begin
            rd_val = {23'h000000, right_q, frame_cnt_q};
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
      if (paddr[1:0] != 2'h0) begin
         rd_val = 32'h0000_0000;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup && !pwrite) begin
            prdata <= rd_val;
         end else if (acc_done) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         mix_sel_q <= mix_rst[`SMX_MIX_SEL_HI:`SMX_MIX_SEL_LO];
         att_q <= mix_rst[`SMX_ATT_HI:`SMX_ATT_LO];
         mix_input_invert_q <= mix_rst[`SMX_INV_BIT];
         first_channel_slot_q <= `SMX_FIRST_CHANNEL_SLOT_RST;
         second_channel_slot_q <= `SMX_SECOND_CHANNEL_SLOT_RST;
         fmt_q <= `SMX_FMT_RST;
      end else if (acc_done && pwrite && mapped) begin
         case (idx)
            `SMX_IDX_MIX_CFG: begin
               // Reserved bits are not stored
               mix_sel_q <= pwdata[`SMX_MIX_SEL_HI:`SMX_MIX_SEL_LO];
               att_q <= pwdata[`SMX_ATT_HI:`SMX_ATT_LO];
               mix_input_invert_q <= pwdata[`SMX_INV_BIT];
            end
            `SMX_IDX_FIRST_CHANNEL_SLOT: begin
               first_channel_slot_q <= pwdata[`SMX_SLOT_HI:`SMX_SLOT_LO];
            end
            `SMX_IDX_SECOND_CHANNEL_SLOT: begin
               second_channel_slot_q <= pwdata[`SMX_SLOT_HI:`SMX_SLOT_LO];
            end
            `SMX_IDX_PORT_CFG: begin
               fmt_q <= pwdata[`SMX_FMT_HI:`SMX_FMT_LO];
            end
            default: begin
               fmt_q <= fmt_q;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Pin synchronisers and bit clock edges
   // -------------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         bclk_m_q <= 1'b0;
         bclk_s_q <= 1'b0;
         bclk_p_q <= 1'b0;
         fs_m_q <= 1'b0;
         fs_s_q <= 1'b0;
         din_m_q <= 1'b0;
         din_s_q <= 1'b0;
      end else begin
         bclk_m_q <= bclk;
         bclk_s_q <= bclk_m_q;
         bclk_p_q <= bclk_s_q;
         fs_m_q <= fsync;
         fs_s_q <= fs_m_q;
         din_m_q <= general_input_pin;
         din_s_q <= din_m_q;
      end
   end

   wire b_rise = bclk_s_q & ~bclk_p_q;
   wire b_fall = ~bclk_s_q & bclk_p_q;
   wire fs_up = fs_s_q & ~fs_last_q;
   wire fs_dn = ~fs_s_q & fs_last_q;
   wire is_tdm = (fmt_q == `SMX_FMT_TDM);
   wire is_i2s = (fmt_q == `SMX_FMT_I2S);
   // I2S frames open on the falling frame sync, TDM and LJ on the rising one
   wire frame_start = b_rise & (is_i2s ? fs_dn : fs_up);
   wire half_start = b_rise & ~is_tdm & (is_i2s ? fs_up : fs_dn);
   wire [4:0] bit_idx = pos_q[4:0];
   wire [5:0] eff_slot = is_tdm ? pos_q[10:5] : {right_q, pos_q[9:5]};

   // -------------------------------------------------------------------------
   // Mixers
   // -------------------------------------------------------------------------
   wire [31:0] mix1;
   wire [31:0] mix2;
   wire mode1 = (mix_sel_q == `SMX_MIX_TO_CH1);
   wire mode2 = (mix_sel_q == `SMX_MIX_TO_CH2);
   wire mode3 = (mix_sel_q == `SMX_MIX_INDEP);

   smx_mix u_mix1 (
      .own_smp(ch1_smp),
      .other_smp(ch2_smp),
      .other_en(mode1),
      .ser_smp(in1_q),
      .ser_en(mode1 | mode3),
      .atten(att_q),
      .invert(mix_input_invert_q),
      .mix_out(mix1)
   );

   smx_mix u_mix2 (
      .own_smp(ch2_smp),
      .other_smp(ch1_smp),
      .other_en(mode2),
      .ser_smp(in2_q),
      .ser_en(mode2 | mode3),
      .atten(att_q),
      .invert(mix_input_invert_q),
      .mix_out(mix2)
   );

   // -------------------------------------------------------------------------
   // Frame position, receive and word latch
   // -------------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         fs_last_q <= 1'b0;
         pos_q <= 11'h000;
         pos_vld_q <= 1'b0;
         right_q <= 1'b0;
         rx_sh_q <= 32'h0000_0000;
         in1_q <= 32'h0000_0000;
         in2_q <= 32'h0000_0000;
         tx1_q <= 32'h0000_0000;
         tx2_q <= 32'h0000_0000;
         frame_cnt_q <= 8'h00;
      end else if (b_rise) begin
         fs_last_q <= fs_s_q;
         if (frame_start) begin
            // Words for the coming frame; zero select passes channels through
            tx1_q <= mix1;
            tx2_q <= mix2;
            frame_cnt_q <= frame_cnt_q + 8'h01;
            right_q <= 1'b0;
            pos_q <= is_i2s ? 11'h7ff : 11'h000;
            pos_vld_q <= ~is_i2s;
         end else if (half_start) begin
            right_q <= 1'b1;
            pos_q <= is_i2s ? 11'h7ff : 11'h000;
            pos_vld_q <= ~is_i2s;
         end else begin
            pos_q <= pos_q + 11'h001;
            pos_vld_q <= 1'b1;
            if (pos_vld_q) begin
               rx_sh_q <= {rx_sh_q[30:0], din_s_q};
               if (bit_idx == `SMX_SLOT_BITS) begin
                  if (eff_slot == 6'h00) begin
                     in1_q <= {rx_sh_q[30:0], din_s_q};
                  end
                  if (eff_slot == 6'h01) begin
                     in2_q <= {rx_sh_q[30:0], din_s_q};
                  end
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Transmit on the falling bit clock edge
   // -------------------------------------------------------------------------
   wire [5:0] nxt_slot = is_tdm ? pos_q[10:5] : {right_q, pos_q[9:5]};
   // A held position is the I2S gap bit: nothing is driven there
   wire tx_ok = pos_vld_q;
   wire [4:0] nxt_bit = pos_q[4:0];
   wire [5:0] use_slot = nxt_slot;
   wire hit1 = tx_ok & (use_slot == first_channel_slot_q);
   wire hit2 = tx_ok & (use_slot == second_channel_slot_q);

   always @(posedge ref_clk) begin
      if (reset) begin
         sdout <= 1'b0;
         sdout_oe <= 1'b0;
      end else if (b_fall) begin
         // MSB first; slot placement does not depend on the mix mode
         if (hit1) begin
            sdout <= tx1_q[`SMX_SLOT_BITS - nxt_bit];
            sdout_oe <= 1'b1;
         end else if (hit2) begin
            sdout <= tx2_q[`SMX_SLOT_BITS - nxt_bit];
            sdout_oe <= 1'b1;
         end else begin
            sdout <= 1'b0;
            sdout_oe <= 1'b0;
         end
      end
   end

endmodule

// [testbench/smx_top_asserts.sv]
// Port checker for the serial input mix block
module smx_top_asserts (
   input wire ref_clk,
   input wire reset,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [31:0] ch1_smp,
   input wire [31:0] ch2_smp,
   input wire bclk,
   input wire fsync,
   input wire general_input_pin,
   input wire sdout,
   input wire sdout_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Helpers
   // ------
   wire setup = psel && !penable;
   wire rd_ok = pready && !pwrite;
   wire mapped = paddr[1:0] == 2'h0 && (paddr[7:2] == 6'h0a || paddr[7:2] == 6'h0b
      || paddr[7:2] == 6'h0c || paddr[7:2] == 6'h10 || paddr[7:2] == 6'h11);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // ------
   // Assertions
   // ------
   chk_ready_once: assert property (setup |=> pready ##1 !pready)
      else $error("pready not a single pulse after setup");
   chk_ready_cause: assert property (pready |-> $past(setup))
      else $error("pready without setup");
   chk_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not follow address map");
   chk_mix_resv: assert property (rd_ok && paddr == 8'h28 |-> prdata[2:0] == 3'h0
      && prdata[31:8] == 24'h0) else $error("mix reserved bits not zero");
   chk_slot_resv: assert property (rd_ok && (paddr == 8'h2c || paddr == 8'h30)
      |-> prdata[31:6] == 26'h0) else $error("slot reserved bits not zero");
   chk_err_rdzero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   chk_idle_low: assert property (!sdout_oe |-> !sdout)
      else $error("sdout high outside slot");
   chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !sdout_oe && !pready)
      else $error("outputs active after reset");
   cover property (pready && pwrite);
   cover property (pready && pslverr);
   cover property ($rose(sdout_oe));
endmodule

bind smx_top smx_top_asserts u_chk (.ref_clk, .reset, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .ch1_smp, .ch2_smp, .bclk, .fsync,
   .general_input_pin, .sdout, .sdout_oe);

// [testbench/smx_host_model.sv]
// Host audio processor model: TDM, I2S and LJ frames in and out
module smx_host_model (
   input wire logic ref_clk,
   output logic bclk,
   output logic fsync,
   output logic general_input_pin,
   input wire logic sdout,
   input wire logic sdout_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [0:2047] rx_d;
   logic [0:2047] rx_oe;
   initial begin
      bclk = 0;
      fsync = 0;
      general_input_pin = 0;
   end
   // One frame of ns slots; pins move on ref_clk edges, 80 ns bit clock, still between
   // frames; hl > 0 splits the frame in halves, inv flips the frame sync as in I2S;
   task automatic frame(input int ns, input int hl, input logic inv, input [31:0] w0,
      input [31:0] w1);
      int i;
      logic [63:0] w;
      w = {w0, w1};
      @(posedge ref_clk);
      for (i = -1; i <= ns * 32; i++) begin
         bclk <= 1'b0;
         fsync <= inv ^ ((i == -1) || (i < hl));
         if (i >= 0 && i < 64) begin
            general_input_pin <= w[63 - i];
         end else begin
            general_input_pin <= ~general_input_pin;
         end
         repeat (4) @(posedge ref_clk);
         bclk <= 1'b1;
         if (i >= 0) begin
            rx_d[i] = sdout;
            rx_oe[i] = sdout_oe;
         end
         repeat (4) @(posedge ref_clk);
      end
      bclk <= 1'b0;
      general_input_pin <= ~general_input_pin;
   endtask
endmodule

// [testbench/smx_top_bench.sv]
// Self-checking bench for the serial input mix block
module smx_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, ch1_smp, ch2_smp, r, e1, e2;
   logic bclk, fsync, general_input_pin, sdout, sdout_oe, e;
   int n_mismatch = 0;
   int n_tests = 0;
   int s;
   localparam logic [31:0] W0 = 32'h00004000;
   localparam logic [31:0] W1 = 32'hfffff800;
   smx_top DUT (.ref_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .ch1_smp, .ch2_smp, .bclk, .fsync, .general_input_pin,
      .sdout, .sdout_oe);
   smx_host_model host (.ref_clk, .bclk, .fsync, .general_input_pin, .sdout, .sdout_oe);
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ------
   // Tasks
   // ------
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input [127:0] seen, input [127:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input [7:0] a, input [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] x, input string n);
      apb(0, a, 0);
      chk(n, r, x);
   endtask
   function automatic [31:0] mixv(input [31:0] a, b, w, input [1:0] at, input iv);
      logic signed [31:0] v;
      v = $signed(w) >>> at;
      if (iv) v = -v;
      return a + b + v;
   endfunction
   // ------
   // Sequence
   // ------
   initial begin
      reset = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      ch1_smp = 32'h00100000;
      ch2_smp = 32'h00020000;
      repeat (6) @(posedge ref_clk);
      reset <= 0;
      rd(8'h28, 0, "mix_cfg");
      rd(8'h2c, 0, "first_channel_slot");
      rd(8'h30, 1, "second_channel_slot");
      apb(0, 8'h3c, 0);
      chk("unmapped_err", e, 1);
      $display("reset values done");
      apb(1, 8'h28, 32'hf8);
      rd(8'h28, 32'hf8, "mix_resv");
      apb(1, 8'h2c, 32'h3f);
      rd(8'h2c, 32'h3f, "slot_resv");
      apb(1, 8'h2c, 0);
      $display("reserved bits done");
      for (s = 0; s < 4; s++) begin
         apb(1, 8'h28, {24'h0, s[1:0], s[1:0], s[0], 3'h0});
         host.frame(4, 0, 0, W0, W1);
         host.frame(4, 0, 0, W0, W1);
         e1 = ch1_smp;
         e2 = ch2_smp;
         if (s == 1) e1 = mixv(ch1_smp, ch2_smp, W0, 1, 1);
         if (s == 2) e2 = mixv(ch1_smp, ch2_smp, W1, 2, 0);
         if (s == 3) e1 = mixv(ch1_smp, 0, W0, 3, 1);
         if (s == 3) e2 = mixv(ch2_smp, 0, W1, 3, 1);
         chk("slot0", host.rx_d[0+:32], e1);
         chk("slot1", host.rx_d[32+:32], e2);
         chk("oe_map", host.rx_oe[0+:128], {64'hffffffffffffffff, 64'h0});
      end
      $display("mix modes done");
      apb(1, 8'h28, 0);
      apb(1, 8'h2c, 2);
      apb(1, 8'h30, 33);
      host.frame(34, 0, 0, W0, W1);
      chk("slot2", host.rx_d[64+:32], ch1_smp);
      chk("slot33", host.rx_d[1056+:32], ch2_smp);
      chk("unused_oe", host.rx_oe[0+:64], 0);
      chk("unused_d", host.rx_d[0+:64], 0);
      $display("slot map done");
      apb(1, 8'h2c, 0);
      apb(1, 8'h30, 32);
      apb(1, 8'h40, 2);
      host.frame(4, 64, 0, W0, W1);
      chk("lj_left0", host.rx_d[0+:32], ch1_smp);
      chk("lj_right0", host.rx_d[65+:32], ch2_smp);
      chk("lj_oe_l", host.rx_oe[0+:33], 33'h1fffffffe);
      chk("lj_oe_r", host.rx_oe[64+:34], 34'h1fffffffe);
      apb(1, 8'h40, 1);
      host.frame(4, 64, 1, W0, W1);
      host.frame(4, 64, 1, W0, W1);
      chk("i2s_left0", host.rx_d[1+:32], ch1_smp);
      chk("i2s_right0", host.rx_d[66+:32], ch2_smp);
      chk("i2s_oe_l", host.rx_oe[0+:34], 34'h1fffffffe);
      chk("i2s_oe_r", host.rx_oe[65+:34], 34'h1fffffffe);
      $display("half frame formats done");
      give_verdict();
   end
endmodule
